// ---- rtl/serial_port_config_regs.sv ----
`timescale 1ns/100ps
module serial_port_config_regs (
    input  wire logic        i_clk,
    input  wire logic        i_rst,
    input  wire logic        i_i2c_mode,
    input  wire logic        i_wr,
    input  wire logic        i_rd,
    input  wire logic [11:0] i_addr,
    input  wire logic [7:0]  i_wdata,
    input  wire logic        i_xfer_start,
    input  wire logic        i_byte_done,
    input  wire logic        i_buffered_reg,
    input  wire logic [7:0]  i_active_data,
    input  wire logic [7:0]  i_buffer_data,
    output logic      [7:0]  o_rdata,
    output logic             o_lsb_first,
    output logic      [11:0] o_next_addr,
    output logic             o_data_pin_rd_en,
    output logic             o_sdo_oe,
    output logic             o_read_buffered,
    output logic             o_soft_reset,
    output logic      [15:0] o_user_version_id
);
    logic        i2c_mode_s;
    logic [7:0]  port_cfg;
    logic [7:0]  next_port_cfg;
    logic [7:0]  readback;
    logic [7:0]  version_lo;
    logic [7:0]  version_hi;
    logic        soft_clear;
    logic        we_readback;
    logic        we_lo;
    logic        we_hi;
    logic        spi_lsb;
    logic        spi_sdo;
    logic [7:0]  next_rdata;
    logic [11:0] next_addr;
    logic        next_data_pin_rd_en;
    logic        next_sdo_oe;
    logic        next_read_buffered;
    logic        next_soft_reset;
    logic        next_lsb_first;
    logic [15:0] next_user_version_id;
    logic        hit_port_cfg;
    logic        hit_readback;
    logic        hit_version_lo;
    logic        hit_version_hi;
    logic        we_port_cfg;
    logic [7:0]  readback_wdata;

    // mode strap pin crosses in from outside
    spcfg_sync u_mode_sync (
        .i_clk (i_clk),
        .i_rst (i_rst),
        .i_d   (i_i2c_mode),
        .o_q   (i2c_mode_s)
    );

    // address decode shared by the write enables and the soft reset pulse
    always_comb begin
        hit_port_cfg   = (i_addr == spcfg_pkg::ADDR_PORT_CFG);
        hit_readback   = (i_addr == spcfg_pkg::ADDR_READBACK);
        hit_version_lo = (i_addr == spcfg_pkg::ADDR_VERSION_LO);
        hit_version_hi = (i_addr == spcfg_pkg::ADDR_VERSION_HI);
    end

    // soft reset takes effect on the cycle after the write; bit itself never stored as 1
    assign soft_clear  = o_soft_reset;
    assign we_port_cfg = i_wr && hit_port_cfg;
    assign we_readback = i_wr && hit_readback;
    assign we_lo       = i_wr && hit_version_lo;
    assign we_hi       = i_wr && hit_version_hi;

    always_comb begin
        next_port_cfg = port_cfg;
        if (soft_clear) begin
            next_port_cfg = spcfg_pkg::RST_PORT_CFG;
        end else if (we_port_cfg) begin
            // keep only the two mode bits; soft reset, reserved and mirror bits read zero
            next_port_cfg = spcfg_pkg::ZERO_BYTE;
            next_port_cfg[spcfg_pkg::BIT_OUT_SEL]   = i_wdata[spcfg_pkg::BIT_OUT_SEL];
            next_port_cfg[spcfg_pkg::BIT_LSB_FIRST] = i_wdata[spcfg_pkg::BIT_LSB_FIRST];
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            port_cfg <= spcfg_pkg::RST_PORT_CFG;
        end else begin
            port_cfg <= next_port_cfg;
        end
    end

    // readback source byte keeps its one field; every other bit reads zero
    always_comb begin
        readback_wdata                             = spcfg_pkg::ZERO_BYTE;
        readback_wdata[spcfg_pkg::BIT_RB_BUFFERED] = i_wdata[spcfg_pkg::BIT_RB_BUFFERED];
    end

    spcfg_byte_reg #(.RESET_VALUE(spcfg_pkg::RST_READBACK)) u_readback (
        .i_clk   (i_clk),
        .i_rst   (i_rst),
        .i_clear (soft_clear),
        .i_we    (we_readback),
        .i_wdata (readback_wdata),
        .o_q     (readback)
    );

    spcfg_byte_reg #(.RESET_VALUE(spcfg_pkg::RST_VERSION)) u_version_lo (
        .i_clk   (i_clk),
        .i_rst   (i_rst),
        .i_clear (soft_clear),
        .i_we    (we_lo),
        .i_wdata (i_wdata),
        .o_q     (version_lo)
    );

    spcfg_byte_reg #(.RESET_VALUE(spcfg_pkg::RST_VERSION)) u_version_hi (
        .i_clk   (i_clk),
        .i_rst   (i_rst),
        .i_clear (soft_clear),
        .i_we    (we_hi),
        .i_wdata (i_wdata),
        .o_q     (version_hi)
    );

    // both SPI-only bits are forced off in I2C mode
    assign spi_lsb = port_cfg[spcfg_pkg::BIT_LSB_FIRST] && !i2c_mode_s;
    assign spi_sdo = port_cfg[spcfg_pkg::BIT_OUT_SEL] && !i2c_mode_s;

    always_comb begin
        next_rdata = spcfg_pkg::ZERO_BYTE;
        if (i_rd) begin
            case (i_addr)
                spcfg_pkg::ADDR_PORT_CFG: begin
                    next_rdata = port_cfg;
                end
                spcfg_pkg::ADDR_READBACK: begin
                    next_rdata = readback;
                end
                spcfg_pkg::ADDR_VERSION_LO: begin
                    next_rdata = version_lo;
                end
                spcfg_pkg::ADDR_VERSION_HI: begin
                    next_rdata = version_hi;
                end
                default: begin
                    // the registered source bit picks the copy, so a read agrees with o_read_buffered
                    if (i_buffered_reg && o_read_buffered) begin
                        next_rdata = i_buffer_data;
                    end else begin
                        next_rdata = i_active_data;
                    end
                end
            endcase
        end else begin
            next_rdata = o_rdata;
        end
    end

    // read data group: the last read byte stands until the next read
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_rdata <= spcfg_pkg::ZERO_BYTE;
        end else begin
            o_rdata <= next_rdata;
        end
    end

    // address counter group: loaded at transfer start, stepped once per byte
    always_comb begin
        next_addr = o_next_addr;
        if (i_xfer_start) begin
            next_addr = i_addr;
        end else if (i_byte_done) begin
            // steps follow the registered order, so the counter never disagrees with o_lsb_first
            if (o_lsb_first) begin
                next_addr = o_next_addr + spcfg_pkg::ADDR_STEP;
            end else begin
                next_addr = o_next_addr - spcfg_pkg::ADDR_STEP;
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_next_addr <= '0;
        end else begin
            o_next_addr <= next_addr;
        end
    end

    // bit order group
    always_comb begin
        next_lsb_first = spi_lsb;
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_lsb_first <= 1'b0;
        end else begin
            o_lsb_first <= next_lsb_first;
        end
    end

    // pin direction group: exactly one of the two read paths is enabled at a time
    always_comb begin
        next_data_pin_rd_en = !spi_sdo;
        next_sdo_oe         = spi_sdo;
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_data_pin_rd_en <= 1'b1;
            o_sdo_oe         <= 1'b0;
        end else begin
            o_data_pin_rd_en <= next_data_pin_rd_en;
            o_sdo_oe         <= next_sdo_oe;
        end
    end

    // readback source group
    always_comb begin
        next_read_buffered = readback[spcfg_pkg::BIT_RB_BUFFERED];
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_read_buffered <= 1'b0;
        end else begin
            o_read_buffered <= next_read_buffered;
        end
    end

    // soft reset group: one pulse per write; a request while the pulse stands is dropped
    always_comb begin
        next_soft_reset = 1'b0;
        if (we_port_cfg && !o_soft_reset) begin
            next_soft_reset = i_wdata[spcfg_pkg::BIT_SOFT_RESET];
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_soft_reset <= 1'b0;
        end else begin
            o_soft_reset <= next_soft_reset;
        end
    end

    // version id group: the id is only a label; it feeds this output and the register read data mux, nothing else
    always_comb begin
        next_user_version_id = {version_hi, version_lo};
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_user_version_id <= {spcfg_pkg::RST_VERSION, spcfg_pkg::RST_VERSION};
        end else begin
            o_user_version_id <= next_user_version_id;
        end
    end
endmodule : serial_port_config_regs

// ---- inc/spcfg_pkg.sv ----
package spcfg_pkg;
    // register offsets
    localparam logic [11:0] ADDR_PORT_CFG    = 12'h000;
    localparam logic [11:0] ADDR_READBACK    = 12'h004;
    localparam logic [11:0] ADDR_VERSION_LO  = 12'h005;
    localparam logic [11:0] ADDR_VERSION_HI  = 12'h006;
    // serial_port_config and readback fields
    localparam int          BIT_OUT_SEL      = 7;
    localparam int          BIT_LSB_FIRST    = 6;
    localparam int          BIT_SOFT_RESET   = 5;
    localparam int          BIT_RB_BUFFERED  = 0;
    // reset values
    localparam logic [7:0]  RST_PORT_CFG     = 8'h00;
    localparam logic [7:0]  RST_READBACK     = 8'h00;
    localparam logic [7:0]  RST_VERSION      = 8'h00;
    localparam logic [7:0]  ZERO_BYTE        = 8'h00;
    localparam logic [11:0] ADDR_STEP        = 12'h001;
endpackage : spcfg_pkg

// ---- rtl/spcfg_byte_reg.sv ----
`timescale 1ns/100ps
// one byte register with write strobe and synchronous clear
module spcfg_byte_reg #(
    parameter logic [7:0] RESET_VALUE = 8'h00
) (
    input  wire logic       i_clk,
    input  wire logic       i_rst,
    input  wire logic       i_clear,
    input  wire logic       i_we,
    input  wire logic [7:0] i_wdata,
    output logic      [7:0] o_q
);
    logic [7:0] next_q;

    always_comb begin
        next_q = o_q;
        if (i_clear) begin
            next_q = RESET_VALUE;
        end else if (i_we) begin
            next_q = i_wdata;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_q <= RESET_VALUE;
        end else begin
            o_q <= next_q;
        end
    end
endmodule : spcfg_byte_reg

// ---- rtl/spcfg_sync.sv ----
`timescale 1ns/100ps
// two-flop synchroniser for a pin level
module spcfg_sync (
    input  wire logic i_clk,
    input  wire logic i_rst,
    input  wire logic i_d,
    output logic      o_q
);
    logic meta;
    logic next_meta;
    logic next_q;

    always_comb begin
        next_meta = i_d;
        next_q    = meta;
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            meta <= 1'b0;
            o_q  <= 1'b0;
        end else begin
            meta <= next_meta;
            o_q  <= next_q;
        end
    end
endmodule : spcfg_sync

// ---- verif/spcfg_host.sv ----
`timescale 1ns/100ps
module spcfg_host (
    input  wire logic        i_clk,
    input  wire logic [7:0]  i_rdata,
    output logic             o_wr = 1'b0,
    output logic             o_rd = 1'b0,
    output logic             o_start = 1'b0,
    output logic             o_step = 1'b0,
    output logic      [11:0] o_addr = 12'h000,
    output logic      [7:0]  o_wdata = 8'h00
);
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        @(posedge i_clk);
        #10;
        o_addr = a;
        o_wdata = (a == 12'h000) ? {d[7:5], 1'b0, 1'b0, d[5], d[6], d[7]} : d;
        o_wr = 1'b1;
        @(posedge i_clk);
        #10;
        o_wr = 1'b0;
        o_wdata = ~o_wdata;
    endtask : wr
    task automatic rd(input logic [11:0] a, output logic [7:0] d);
        @(posedge i_clk);
        #10;
        o_addr = a;
        o_rd = 1'b1;
        @(posedge i_clk);
        #10;
        o_rd = 1'b0;
        d = i_rdata;
    endtask : rd
    // load the address counter, then step it n times back to back
    task automatic burst(input logic [11:0] a, input int n);
        @(posedge i_clk);
        #10;
        o_addr = a;
        o_start = 1'b1;
        @(posedge i_clk);
        #10;
        o_start = 1'b0;
        o_step = 1'b1;
        repeat (n) @(posedge i_clk);
        #10;
        o_step = 1'b0;
    endtask : burst
endmodule : spcfg_host

// ---- verif/spcfg_properties.sv ----
`timescale 1ns/100ps
module spcfg_properties (
    input wire logic        i_clk,
    input wire logic        i_rst,
    input wire logic        i_i2c_mode,
    input wire logic        i_wr,
    input wire logic        i_rd,
    input wire logic [11:0] i_addr,
    input wire logic [7:0]  i_wdata,
    input wire logic        i_xfer_start,
    input wire logic        i_byte_done,
    input wire logic        i_buffered_reg,
    input wire logic [7:0]  i_active_data,
    input wire logic [7:0]  i_buffer_data,
    input wire logic [7:0]  o_rdata,
    input wire logic        o_lsb_first,
    input wire logic [11:0] o_next_addr,
    input wire logic        o_data_pin_rd_en,
    input wire logic        o_sdo_oe,
    input wire logic        o_read_buffered,
    input wire logic        o_soft_reset,
    input wire logic [15:0] o_user_version_id
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);
    sequence s_sr_write;
        i_wr && i_addr == 12'h000 && i_wdata[5] && !o_soft_reset;
    endsequence
    sequence s_sr_done;
        o_soft_reset ##1 !o_soft_reset ##1 o_user_version_id == 16'h0000;
    endsequence
    sequence s_step;
        i_byte_done && !i_xfer_start;
    endsequence
    a_oe_pin_excl: assert property (o_sdo_oe != o_data_pin_rd_en) else $error("read pin select wrong");
    a_sreset_seq: assert property (s_sr_write |=> s_sr_done) else $error("soft reset wrong");
    a_sreset_once: assert property (o_soft_reset |=> !o_soft_reset) else $error("soft reset stuck");
    a_addr_load: assert property (i_xfer_start |=> o_next_addr == $past(i_addr)) else $error("addr load");
    a_addr_down: assert property (s_step ##0 !o_lsb_first |=> o_next_addr == $past(o_next_addr) - 12'h001)
        else $error("addr not decremented");
    a_addr_up: assert property (s_step ##0 o_lsb_first |=> o_next_addr == $past(o_next_addr) + 12'h001)
        else $error("addr not incremented");
    a_rd_active: assert property (i_rd && i_buffered_reg && !o_read_buffered && i_addr > 12'h006
        |=> o_rdata == $past(i_active_data)) else $error("active readback");
    a_rd_pending: assert property (i_rd && i_buffered_reg && o_read_buffered && i_addr > 12'h006
        |=> o_rdata == $past(i_buffer_data)) else $error("buffered readback");
    a_i2c_quiet: assert property (i_i2c_mode [*6] |-> !o_sdo_oe && !o_lsb_first) else $error("i2c spi bits");
endmodule : spcfg_properties
bind serial_port_config_regs spcfg_properties chk (
    .i_clk             (i_clk),
    .i_rst             (i_rst),
    .i_i2c_mode        (i_i2c_mode),
    .i_wr              (i_wr),
    .i_rd              (i_rd),
    .i_addr            (i_addr),
    .i_wdata           (i_wdata),
    .i_xfer_start      (i_xfer_start),
    .i_byte_done       (i_byte_done),
    .i_buffered_reg    (i_buffered_reg),
    .i_active_data     (i_active_data),
    .i_buffer_data     (i_buffer_data),
    .o_rdata           (o_rdata),
    .o_lsb_first       (o_lsb_first),
    .o_next_addr       (o_next_addr),
    .o_data_pin_rd_en  (o_data_pin_rd_en),
    .o_sdo_oe          (o_sdo_oe),
    .o_read_buffered   (o_read_buffered),
    .o_soft_reset      (o_soft_reset),
    .o_user_version_id (o_user_version_id)
);

// ---- verif/tb_top.sv ----
`timescale 1ns/100ps
module tb_top;
    logic        i_clk = 1'b0, i_rst = 1'b1, i_i2c_mode = 1'b0, i_buffered_reg = 1'b0;
    logic        i_wr, i_rd, i_xfer_start, i_byte_done, o_lsb_first, o_data_pin_rd_en, o_sdo_oe;
    logic        o_read_buffered, o_soft_reset;
    logic [11:0] i_addr, o_next_addr;
    logic [7:0]  i_wdata, o_rdata, v;
    logic [7:0]  i_active_data = 8'h11, i_buffer_data = 8'h22;
    logic [15:0] o_user_version_id;
    int          n_errors = 0, samples_checked = 0;
    always #50 i_clk = ~i_clk;
    serial_port_config_regs uut (.i_clk(i_clk), .i_rst(i_rst), .i_i2c_mode(i_i2c_mode), .i_wr(i_wr),
        .i_rd(i_rd), .i_addr(i_addr), .i_wdata(i_wdata), .i_xfer_start(i_xfer_start),
        .i_byte_done(i_byte_done), .i_buffered_reg(i_buffered_reg), .i_active_data(i_active_data),
        .i_buffer_data(i_buffer_data), .o_rdata(o_rdata), .o_lsb_first(o_lsb_first),
        .o_next_addr(o_next_addr), .o_data_pin_rd_en(o_data_pin_rd_en), .o_sdo_oe(o_sdo_oe),
        .o_read_buffered(o_read_buffered), .o_soft_reset(o_soft_reset), .o_user_version_id(o_user_version_id));
    spcfg_host host (.i_clk(i_clk), .i_rdata(o_rdata), .o_wr(i_wr), .o_rd(i_rd), .o_start(i_xfer_start),
        .o_step(i_byte_done), .o_addr(i_addr), .o_wdata(i_wdata));
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic wt(input int n);
        repeat (n) @(posedge i_clk);
        #10;
    endtask : wt
    task automatic results;
        $display("checked %0d mismatches %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : results
    task automatic t_defaults;
        chk(o_sdo_oe, 1'b0);
        chk(o_data_pin_rd_en, 1'b1);
        chk(o_lsb_first, 1'b0);
        chk(o_user_version_id, 16'h0000);
        chk(o_read_buffered, 1'b0);
        host.rd(12'h004, v);
        chk(v, 8'h00);
        $display("defaults done");
    endtask : t_defaults
    task automatic t_order;
        host.burst(12'h010, 2);
        chk(o_next_addr, 12'h00E);
        host.wr(12'h000, 8'hC0);
        wt(2);
        chk(o_sdo_oe, 1'b1);
        chk(o_data_pin_rd_en, 1'b0);
        host.rd(12'h000, v);
        chk(v, 8'hC0);
        host.burst(12'h010, 3);
        chk(o_next_addr, 12'h013);
        $display("order done");
    endtask : t_order
    task automatic t_i2c;
        i_i2c_mode = 1'b1;
        wt(6);
        chk(o_sdo_oe, 1'b0);
        chk(o_lsb_first, 1'b0);
        host.burst(12'h010, 2);
        chk(o_next_addr, 12'h00E);
        i_i2c_mode = 1'b0;
        wt(6);
        chk(o_lsb_first, 1'b1);
        $display("i2c done");
    endtask : t_i2c
    task automatic t_version_readback;
        host.wr(12'h005, 8'h3C);
        host.wr(12'h006, 8'hA5);
        wt(1);
        chk(o_user_version_id, 16'hA53C);
        chk(o_sdo_oe, 1'b1);
        host.rd(12'h006, v);
        chk(v, 8'hA5);
        i_buffered_reg = 1'b1;
        host.rd(12'h100, v);
        chk(v, 8'h11);
        host.wr(12'h004, 8'h01);
        wt(1);
        chk(o_read_buffered, 1'b1);
        host.rd(12'h100, v);
        chk(v, 8'h22);
        i_buffered_reg = 1'b0;
        $display("version readback done");
    endtask : t_version_readback
    task automatic t_soft_reset;
        host.wr(12'h000, 8'hE0);
        chk(o_soft_reset, 1'b1);
        wt(1);
        chk(o_soft_reset, 1'b0);
        wt(1);
        chk(o_user_version_id, 16'h0000);
        chk(o_sdo_oe, 1'b0);
        chk(o_read_buffered, 1'b0);
        host.rd(12'h000, v);
        chk(v, 8'h00);
        host.rd(12'h004, v);
        chk(v, 8'h00);
        $display("soft reset done");
    endtask : t_soft_reset
    initial begin
        #100000;
        n_errors++;
        results();
    end
    initial begin
        wt(3);
        i_rst = 1'b0;
        t_defaults();
        t_order();
        t_i2c();
        t_version_readback();
        t_soft_reset();
        results();
    end
endmodule : tb_top
